// [sim/bit_shift_asserts.sv]
// Purpose: port checks of the bit datapath
// Assumes: result one clock after request
// Notes:   w_q s_q b_q hold what a request saw
module bit_shift_asserts
   import bit_shift_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire bit_req_t   req,
   input wire logic [4:0] io_rd_addr,
   input wire bit_res_t   res,
   input wire logic [7:0] io_rd_data
);
   logic [7:0]  w, s, w_q, s_q;
   logic [2:0]  b_q;
   logic [15:0] hit;
   // one-hot of the op taken
   assign hit = req.valid ? 16'h0001 << req.op : 16'h0000;
   assign w = res.work;
   assign s = res.status_register;
   // state at the request edge
   always_ff @(posedge clk)
   begin
      w_q <= w;
      s_q <= s;
      b_q <= req.bit_sel;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_SET: assert property (hit[io_bit_set_op] && io_rd_addr == req.io_addr |=> io_rd_data[b_q])
      else $error("io bit not set");
   AST_CLR: assert property (hit[io_bit_clear_op] && io_rd_addr == req.io_addr |=> !io_rd_data[b_q])
      else $error("io bit not cleared");
   AST_LSL: assert property (hit[shift_left_logical_op] |=> w == {w_q[6:0], 1'b0} && s[0] == w_q[7])
      else $error("left shift wrong");
   AST_LSR: assert property (hit[shift_right_logical_op] |=> {w, s[0]} == {1'b0, w_q})
      else $error("right shift wrong");
   AST_ROL: assert property (hit[rotate_left_carry_op] |=> {s[0], w} == {w_q, s_q[0]})
      else $error("rotate left wrong");
   AST_ROR: assert property (hit[rotate_right_carry_op] |=> {w, s[0]} == {s_q[0], w_q})
      else $error("rotate right wrong");
   AST_SWAP: assert property (hit[swap_nibble_op] |=> w == {w_q[3:0], w_q[7:4]} && s == s_q)
      else $error("swap wrong");
   AST_BST: assert property (hit[bit_to_transfer_op] |=> s[6] == w_q[b_q] && w == w_q)
      else $error("bit store wrong");
   AST_BLD: assert property (hit[transfer_to_bit_op] |=> w == (w_q & ~(8'h01 << b_q) | {7'h00, s_q[6]} << b_q))
      else $error("bit load wrong");
   AST_ASR: assert property (hit[shift_right_arith_op] |=> {w, s[0]} == {w_q[7], w_q})
      else $error("arithmetic shift wrong");
   AST_FLAGS: assert property (|hit[7:3] |=> s[3:1] == {w[7] ^ s[0], w[7], w == 8'h00})
      else $error("shift flags wrong");
   AST_KEEP: assert property (req.valid && hit[7:3] == 5'h00 |=> s[3:0] == s_q[3:0])
      else $error("flags moved on a non-shift op");
   cover property (hit[rotate_left_carry_op]);
   cover property (hit[io_bit_set_op] && io_rd_addr == req.io_addr);
   cover property (hit[transfer_to_bit_op]);
endmodule : bit_shift_asserts
bind bit_shift_flag_datapath bit_shift_asserts chk_u (.clk(clk), .rst_n(rst_n), .req(req),
   .io_rd_addr(io_rd_addr), .res(res), .io_rd_data(io_rd_data));

// [sim/testbench.sv]
// Purpose: random run of the bit datapath
// Assumes: one request per clock
// Notes:   bench keeps its own copy of state
module testbench
   import bit_shift_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0, rst_n = 1'b0, work_load = 1'b0, ev = 1'b0, rd_mix = 1'b0;
   logic [7:0] work_load_data = 8'h00, ew = 8'h00, es = 8'h00, erd = 8'h00, io_rd_data, eio [32];
   logic [4:0] io_rd_addr = 5'h00;
   bit_req_t   req = '0;
   bit_res_t   res;
   int         n_fail, checks, cyc, seed = 1;
   always #4 clk = ~clk;
   bit_shift_flag_datapath dut_u (.clk(clk), .rst_n(rst_n), .req(req), .work_load(work_load),
      .work_load_data(work_load_data), .io_rd_addr(io_rd_addr), .res(res), .io_rd_data(io_rd_data));
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: %h vs %h", $time, g, e);
      end
   endtask : cmp
   task automatic tally_and_finish;
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   // expected {carry, byte} after a shift, rotate or swap; other codes keep both
   function automatic logic [8:0] shift_model(input bit_op_t op, input logic [7:0] w, input logic c);
      case (op)
         shift_left_logical_op:  shift_model = {w, 1'b0};
         shift_right_logical_op: shift_model = {w[0], 1'b0, w[7:1]};
         rotate_left_carry_op:   shift_model = {w, c};
         rotate_right_carry_op:  shift_model = {w[0], c, w[7:1]};
         shift_right_arith_op:   shift_model = {w[0], w[7], w[7:1]};
         swap_nibble_op:         shift_model = {c, w[3:0], w[7:4]};
         default:                shift_model = {c, w};
      endcase
   endfunction : shift_model
   // expected S V N Z C from the shifted byte and the carry it left
   function automatic logic [4:0] flag_model(input logic [7:0] w, input logic c);
      flag_model = {w[7] ^ (w[7] ^ c), w[7] ^ c, w[7], w == 8'h00, c};
   endfunction : flag_model
   // drive a request, check the last one, advance the copy
   task automatic step(input logic v, input bit_op_t op, input logic [2:0] b, input logic [4:0] a,
                       input logic ld, input logic [7:0] d);
      logic       c;
      logic [4:0] r;
      r = rd_mix ? 5'($random(seed)) : a;
      @(posedge clk);
      req <= '{v, op, b, a};
      work_load <= ld;
      work_load_data <= d;
      io_rd_addr <= r;
      #1;
      cmp(res.work, ew);
      cmp(res.status_register, es);
      cmp(io_rd_data, erd);
      cmp({7'h00, res.result_valid}, {7'h00, ev});
      c = es[0];
      ev = v;
      if (v)
      begin
         case (op)
            io_bit_set_op:      eio[a][b] = 1'b1;
            io_bit_clear_op:    eio[a][b] = 1'b0;
            bit_to_transfer_op: es[6] = ew[b];
            transfer_to_bit_op: ew[b] = es[6];
            default:            {c, ew} = shift_model(op, ew, c);
         endcase
         // flags S V N Z C after shifts only, swap leaves them
         if (op inside {[shift_left_logical_op:shift_right_arith_op]})
            es[4:0] = flag_model(ew, c);
      end
      else if (ld)
         ew = d;
      erd = eio[r];
   endtask : step
   // hang guard, the run needs some 820 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial
   begin
      foreach (eio[i]) eio[i] = 8'h00;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      step(1'b0, op_none, 3'h0, 5'h1f, 1'b1, 8'h81);
      step(1'b1, shift_left_logical_op, 3'h0, 5'h1f, 1'b0, 8'h00);
      step(1'b1, io_bit_set_op, 3'h7, 5'h1f, 1'b0, 8'h00);
      step(1'b1, io_bit_clear_op, 3'h0, 5'h1f, 1'b1, 8'h00);
      step(1'b0, op_none, 3'h0, 5'h00, 1'b1, 8'h80);
      step(1'b1, shift_right_arith_op, 3'h0, 5'h00, 1'b0, 8'h00);
      step(1'b1, bit_to_transfer_op, 3'h7, 5'h00, 1'b0, 8'h00);
      step(1'b1, transfer_to_bit_op, 3'h0, 5'h00, 1'b0, 8'h00);
      step(1'b1, bit_op_t'(4'hf), 3'h0, 5'h00, 1'b0, 8'h00);
      // random mix, idle one time in eight, read port often away from the written byte
      rd_mix = 1'b1;
      repeat (800)
         step($random(seed) % 8 != 0, bit_op_t'(4'($random(seed))), 3'($random(seed)),
              5'($random(seed)), 1'($random(seed)), 8'($random(seed)));
      step(1'b0, op_none, 3'h0, 5'h00, 1'b0, 8'h00);
      // mid-run reset: registers, flags and I/O byte 0 must read clear, byte 31 only bit 2 set after reset
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rd_mix = 1'b0;
      {ew, es, erd, ev} = '0;
      foreach (eio[i]) eio[i] = 8'h00;
      step(1'b1, io_bit_set_op, 3'h2, 5'h1f, 1'b0, 8'h00);
      step(1'b1, rotate_left_carry_op, 3'h0, 5'h00, 1'b0, 8'h00);
      step(1'b0, op_none, 3'h0, 5'h1f, 1'b0, 8'h00);
      tally_and_finish();
   end
endmodule : testbench

// [src/bit_shift_flag_datapath.sv]
// Purpose: bit and shift datapath on one working register, status flags and a small I/O file
// Assumes: one request per cycle, results appear one clock after the request
// Notes:   the working register is loadable from outside; I/O file is 32 bytes
// Operation
// [RQ1] I/O bit set forces selected bit to one, others kept
// [RQ2] I/O bit clear forces selected bit to zero, others kept
// [RQ3] logical left shift moves bits up, zero into bit zero
// [RQ4] logical right shift moves bits down, zero into bit seven
// [RQ5] rotate left: old carry into bit zero, old bit seven to carry
// [RQ6] rotate right: old carry into bit seven, old bit zero to carry
// [RQ7] swap exchanges upper and lower nibbles at once
// [RQ8] bit store copies chosen register bit into transfer flag
// [RQ9] bit load copies transfer flag into chosen register bit
// [RQ10] arithmetic right shift keeps bit seven, preserving sign
// [RQ11] shifts and rotates update Z, C, N, V; other operations do not
`include "bit_shift_params.svh"
module bit_shift_flag_datapath
   import bit_shift_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire bit_req_t              req,
   input  wire logic                  work_load,
   input  wire logic [7:0]            work_load_data,
   input  wire logic [`IO_ADDR_W-1:0] io_rd_addr,
   output bit_res_t                   res,
   output logic      [7:0]            io_rd_data
);
   localparam int IO_DEPTH = 1 << `IO_ADDR_W;

   // decoded request, one strobe per group of operations
   logic                  do_set;
   logic                  do_clear;
   logic                  do_shift;
   logic                  do_swap;
   logic                  do_store;
   logic                  do_load;
   logic                  do_ext_load;
   // working register
   logic [7:0]            work_q;
   logic [7:0]            work_d;
   // status flags
   logic [7:0]            status_q;
   logic [7:0]            status_d;
   // I/O file and its write port
   logic [7:0]            io_mem_q [IO_DEPTH];
   logic                  io_wr_en;
   logic [`IO_ADDR_W-1:0] io_wr_addr;
   logic [7:0]            io_wr_data;
   logic [7:0]            io_old;
   logic [7:0]            bit_mask;
   // registered read port and result strobe
   logic [7:0]            io_rd_q;
   logic [7:0]            io_rd_d;
   logic                  valid_q;
   logic                  valid_d;
   // shifter results
   logic [7:0]            shift_out;
   logic                  carry_out;

   // shifter sees the live register and carry, so back to back shifts chain
   shift_unit u_shift
   (
      .op        (req.op),
      .din       (work_q),
      .carry_in  (status_q[`FLAG_C_POS]),
      .dout      (shift_out),
      .carry_out (carry_out)
   );

   // decode once, so each state group below tests one plain strobe
   always_comb
   begin
      do_set      = 1'b0;
      do_clear    = 1'b0;
      do_shift    = 1'b0;
      do_swap     = 1'b0;
      do_store    = 1'b0;
      do_load     = 1'b0;
      do_ext_load = 1'b0;
      if (req.valid)
      begin
         case (req.op)
            io_bit_set_op:
            begin
               do_set = 1'b1;
            end
            io_bit_clear_op:
            begin
               do_clear = 1'b1;
            end
            shift_left_logical_op, shift_right_logical_op, rotate_left_carry_op,
            rotate_right_carry_op, shift_right_arith_op:
            begin
               do_shift = 1'b1;
            end
            swap_nibble_op:
            begin
               do_swap = 1'b1;
            end
            bit_to_transfer_op:
            begin
               do_store = 1'b1;
            end
            transfer_to_bit_op:
            begin
               do_load = 1'b1;
            end
            default:
            begin
               // idle and unused codes change nothing and raise no strobe
               do_set = 1'b0;
            end
         endcase
      end
      else
      begin
         // an outside load loses to a valid request: the datapath owns the register that cycle
         do_ext_load = work_load;
      end
   end

   // working register: shifter result, single-bit load or outside load
   always_comb
   begin
      work_d = work_q;
      if (do_shift || do_swap)
      begin
         work_d = shift_out;                                           // see [RQ7]
      end
      else if (do_load)
      begin
         work_d[req.bit_sel] = status_q[`FLAG_T_POS];                  // see [RQ9]
      end
      else if (do_ext_load)
      begin
         work_d = work_load_data;
      end
   end

   // working register flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         work_q <= `WORK_RESET;
      end
      else
      begin
         work_q <= work_d;
      end
   end

   // status: arithmetic flags follow shifts only, T follows the bit store
   always_comb
   begin
      status_d = status_q;                                             // see [RQ11]
      if (do_shift)
      begin
         // V is N xor C as the shift leaves them; S is N xor V, which collapses to C
         status_d[`FLAG_C_POS] = carry_out;                            // see [RQ11]
         status_d[`FLAG_Z_POS] = (shift_out == 8'h00);                 // see [RQ11]
         status_d[`FLAG_N_POS] = shift_out[7];                         // see [RQ11]
         status_d[`FLAG_V_POS] = shift_out[7] ^ carry_out;             // see [RQ11]
         status_d[`FLAG_S_POS] = carry_out;
      end
      else if (do_store)
      begin
         status_d[`FLAG_T_POS] = work_q[req.bit_sel];                  // see [RQ8]
      end
   end

   // status flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         status_q <= `STATUS_RESET;
      end
      else
      begin
         status_q <= status_d;
      end
   end

   // I/O write port: read-modify-write of one byte with a single bit forced
   always_comb
   begin
      io_old     = io_mem_q[req.io_addr];
      bit_mask   = 8'h01 << req.bit_sel;
      io_wr_en   = do_set || do_clear;
      io_wr_addr = req.io_addr;
      io_wr_data = io_old;
      if (do_set)
      begin
         io_wr_data = io_old | bit_mask;                               // see [RQ1]
      end
      else if (do_clear)
      begin
         io_wr_data = io_old & ~bit_mask;                              // see [RQ2]
      end
   end

   // the file itself; every byte clears on reset so reads never show unknowns
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < IO_DEPTH; i++)
         begin
            io_mem_q[i] <= `IO_RESET;
         end
      end
      else if (io_wr_en)
      begin
         io_mem_q[io_wr_addr] <= io_wr_data;
      end
   end

   // read port forwards a same-cycle write, so a set or clear shows one clock later
   always_comb
   begin
      io_rd_d = io_mem_q[io_rd_addr];
      if (io_wr_en && (io_rd_addr == io_wr_addr))
      begin
         io_rd_d = io_wr_data;
      end
      valid_d = req.valid;
   end

   // read data and result strobe flops
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         io_rd_q <= `IO_RESET;
         valid_q <= 1'b0;
      end
      else
      begin
         io_rd_q <= io_rd_d;
         valid_q <= valid_d;
      end
   end

   // outputs straight from flip-flops
   assign res.result_valid    = valid_q;
   assign res.work            = work_q;
   assign res.status_register = status_q;
   assign io_rd_data          = io_rd_q;
endmodule : bit_shift_flag_datapath

// [src/bit_shift_params.svh]
// Purpose: constants for the bit and shift datapath
// Assumes: 8-bit working register, 8-bit status register
// Notes:   flag positions follow the usual status layout
`ifndef BIT_SHIFT_PARAMS_SVH
`define BIT_SHIFT_PARAMS_SVH
`define FLAG_C_POS      3'd0
`define FLAG_Z_POS      3'd1
`define FLAG_N_POS      3'd2
`define FLAG_V_POS      3'd3
`define FLAG_S_POS      3'd4
`define FLAG_H_POS      3'd5
`define FLAG_T_POS      3'd6
`define FLAG_I_POS      3'd7
`define WORK_RESET      8'h00
`define STATUS_RESET    8'h00
`define IO_RESET        8'h00
`define IO_ADDR_W       5
`endif

// [src/bit_shift_pkg.sv]
// Purpose: types for the bit and shift datapath
// Assumes: constants come from the params header
// Notes:   request and result travel as packed structs
`include "bit_shift_params.svh"
package bit_shift_pkg;
   typedef enum logic [3:0] {
      op_none,
      io_bit_set_op,
      io_bit_clear_op,
      shift_left_logical_op,
      shift_right_logical_op,
      rotate_left_carry_op,
      rotate_right_carry_op,
      shift_right_arith_op,
      swap_nibble_op,
      bit_to_transfer_op,
      transfer_to_bit_op
   } bit_op_t;

   typedef struct packed {
      logic                   valid;
      bit_op_t                op;
      logic [2:0]             bit_sel;
      logic [`IO_ADDR_W-1:0]  io_addr;
   } bit_req_t;

   typedef struct packed {
      logic       result_valid;
      logic [7:0] work;
      logic [7:0] status_register;
   } bit_res_t;
endpackage : bit_shift_pkg

// [src/shift_unit.sv]
// Purpose: combinational shift, rotate and swap of one byte with carry result
// Assumes: op is one of the shift/rotate/swap codes when used
// Notes:   flag update is only meaningful for shifts and rotates
module shift_unit
   import bit_shift_pkg::*;
(
   input  wire bit_op_t    op,
   input  wire logic [7:0] din,
   input  wire logic       carry_in,
   output logic      [7:0] dout,
   output logic            carry_out
);
   // one case per operation, carry passes through for swap
   always_comb
   begin
      dout      = din;
      carry_out = carry_in;
      case (op)
         shift_left_logical_op:
         begin
            dout      = {din[6:0], 1'b0};          // see [RQ3]
            carry_out = din[7];
         end
         shift_right_logical_op:
         begin
            dout      = {1'b0, din[7:1]};          // see [RQ4]
            carry_out = din[0];
         end
         rotate_left_carry_op:
         begin
            dout      = {din[6:0], carry_in};      // see [RQ5]
            carry_out = din[7];
         end
         rotate_right_carry_op:
         begin
            dout      = {carry_in, din[7:1]};      // see [RQ6]
            carry_out = din[0];
         end
         shift_right_arith_op:
         begin
            dout      = {din[7], din[7:1]};        // see [RQ10]
            carry_out = din[0];
         end
         swap_nibble_op:
         begin
            dout      = {din[3:0], din[7:4]};      // see [RQ7]
         end
         default:
         begin
            dout      = din;
            carry_out = carry_in;
         end
      endcase
   end
endmodule : shift_unit
